// >>> core/icc_pkg.sv
// package: register map, field layout and mode codes for the input capture channel
package icc_pkg;
  // register indices on the plain register port
  localparam logic [1:0] ICC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] ICC_ADDR_BUF = 2'h1;
  localparam logic [1:0] ICC_ADDR_IRQ_STAT = 2'h2;
  localparam logic [1:0] ICC_ADDR_IRQ_MASK = 2'h3;
  // control field positions
  localparam int ICC_BIT_SIDL = 13;
  localparam int ICC_BIT_TMR = 7;
  localparam int ICC_BIT_CPI_LO = 5;
  localparam int ICC_BIT_OV = 4;
  localparam int ICC_BIT_BNE = 3;
  localparam logic [15:0] ICC_CTRL_WMASK = 16'h20E7;
  localparam logic [15:0] ICC_CTRL_RESET = 16'h0000;
  // mode codes
  localparam logic [2:0] ICC_MODE_OFF = 3'h0;
  localparam logic [2:0] ICC_MODE_EVERY = 3'h1;
  localparam logic [2:0] ICC_MODE_FALL = 3'h2;
  localparam logic [2:0] ICC_MODE_RISE = 3'h3;
  localparam logic [2:0] ICC_MODE_RISE4 = 3'h4;
  localparam logic [2:0] ICC_MODE_RISE16 = 3'h5;
  localparam logic [2:0] ICC_MODE_UNUSED = 3'h6;
  localparam logic [2:0] ICC_MODE_WAKE = 3'h7;
  localparam logic [3:0] ICC_PRE4_LAST = 4'h3;
  localparam logic [3:0] ICC_PRE16_LAST = 4'hF;
  // interrupt status bit positions
  localparam int ICC_IRQ_CAP = 0;
  localparam int ICC_IRQ_OV = 1;
  localparam int ICC_IRQ_WAKE = 2;

  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } icc_req_t;

  typedef struct packed {
    logic sidl;
    logic tmr_sel;
    logic [1:0] cpi;
    logic [2:0] mode;
  } icc_ctrl_t;
endpackage

// >>> core/icc_capture.sv
// input capture channel: edge detect, prescaler, 4-entry capture fifo, register port
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// Summary of operation
// R1: modes 011 rise, 010 fall, 001 both edges
// R2: modes 100/101 capture every 4th/16th rise
// R3: mode 000 turns channel off
// R4: mode 110 behaves as disabled
// R5: mode 111 wakes on rising edge when asleep
// R6: latch full 16-bit selected timer count
// R7: timer select 1 picks timer b, 0 timer c
// R8: four-entry 16-bit capture fifo
// R9: interrupt every 1 to 4 captures
// R10: every-edge mode ignores captures-per-interrupt field
// R11: read-only overflow flag
// R12: read-only buffer not-empty flag
// R13: stop-in-idle halts channel during idle
// R14: pin event wakes device from sleep, idle
// R15: software sets field 00 for transfers
// R16: unimplemented control bits read zero
// R17: overflow on full capture; buffer read pops oldest
// R18: off mode flushes buffer, overflow, prescaler
module icc_capture
  import icc_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int TW = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_capture_input_pin,
  input wire logic [TW-1:0] i_timer_b_count,
  input wire logic [TW-1:0] i_timer_c_count,
  input wire logic i_cpu_idle,
  input wire logic i_cpu_sleep,
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq,
  output logic o_wake
);
  // =====================================================
  // pin synchroniser and edge detect
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_prev_ff;
  icc_req_t req;
  icc_ctrl_t ctrl;
  logic [15:0] ctrl_ff;
  logic rise;
  logic fall;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign ctrl = '{sidl: ctrl_ff[ICC_BIT_SIDL], tmr_sel: ctrl_ff[ICC_BIT_TMR],
                  cpi: ctrl_ff[ICC_BIT_CPI_LO+1:ICC_BIT_CPI_LO], mode: ctrl_ff[2:0]};

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff <= i_capture_input_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end
  assign rise = pin_s2_ff & ~pin_prev_ff;
  assign fall = ~pin_s2_ff & pin_prev_ff;

  // =====================================================
  // event qualification
  logic halted;
  logic off_mode;
  logic [3:0] pre_ff;
  logic [3:0] pre_last;
  logic cap_evt;

  function automatic logic mode_off(input logic [2:0] m);
    mode_off = (m == ICC_MODE_OFF) || (m == ICC_MODE_UNUSED) || (m == ICC_MODE_WAKE);
  endfunction

  assign halted = ctrl.sidl & i_cpu_idle; // R13
  assign off_mode = (ctrl.mode == ICC_MODE_OFF) || (ctrl.mode == ICC_MODE_UNUSED); // R3 R4
  assign pre_last = (ctrl.mode == ICC_MODE_RISE16) ? ICC_PRE16_LAST : ICC_PRE4_LAST;

  always_comb begin
    cap_evt = 1'b0;
    if (!halted && !mode_off(ctrl.mode)) begin
      case (ctrl.mode)
        ICC_MODE_EVERY: cap_evt = rise | fall; // R1
        ICC_MODE_FALL: cap_evt = fall; // R1
        ICC_MODE_RISE: cap_evt = rise; // R1
        ICC_MODE_RISE4,
        ICC_MODE_RISE16: cap_evt = rise && (pre_ff == pre_last); // R2
        default: cap_evt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pre_ff <= 4'h0;
    end else if (off_mode) begin
      pre_ff <= 4'h0; // R18
    end else if (!halted && rise &&
                 (ctrl.mode == ICC_MODE_RISE4 || ctrl.mode == ICC_MODE_RISE16)) begin
      pre_ff <= (pre_ff == pre_last) ? 4'h0 : pre_ff + 4'h1; // R2
    end
  end

  // wake: rising edge while asleep or idle in mode 111, any capture edge otherwise
  assign o_wake = (i_cpu_sleep | i_cpu_idle) &&
                  (((ctrl.mode == ICC_MODE_WAKE) && rise) || cap_evt); // R5 R14

  // =====================================================
  // capture fifo
  logic [TW-1:0] fifo_ff [DEPTH];
  logic [1:0] wp_ff;
  logic [1:0] rp_ff;
  logic [2:0] cnt_ff;
  logic full;
  logic pop;
  logic push;
  logic ov_ff;
  logic [TW-1:0] cap_val;

  assign full = (cnt_ff == 3'(DEPTH));
  assign pop = req.rd && (req.addr == ICC_ADDR_BUF) && (cnt_ff != 3'h0); // R17
  assign push = cap_evt && !full;
  assign cap_val = ctrl.tmr_sel ? i_timer_b_count : i_timer_c_count; // R6 R7

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        fifo_ff[i] <= '0;
      end
    end else if (push) begin
      fifo_ff[wp_ff] <= cap_val; // R8
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wp_ff <= 2'h0;
      rp_ff <= 2'h0;
      cnt_ff <= 3'h0;
    end else if (off_mode) begin
      wp_ff <= 2'h0; // R18
      rp_ff <= 2'h0;
      cnt_ff <= 3'h0;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 2'h1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 2'h1;
      end
      cnt_ff <= cnt_ff + {2'h0, push} - {2'h0, pop};
    end
  end

  // overflow sticks until the channel is switched off
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ov_ff <= 1'b0;
    end else if (off_mode) begin
      ov_ff <= 1'b0; // R18
    end else if (cap_evt && full) begin
      ov_ff <= 1'b1; // R11 R17
    end
  end

  // =====================================================
  // captures-per-interrupt counter
  logic [1:0] ncap_ff;
  logic cap_irq_evt;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ncap_ff <= 2'h0;
    end else if (off_mode) begin
      ncap_ff <= 2'h0;
    end else if (push) begin
      ncap_ff <= (ncap_ff >= ctrl.cpi) ? 2'h0 : ncap_ff + 2'h1; // R9
    end
  end
  // every-edge mode interrupts on each capture regardless of the field
  // >= keeps a lowered field from skipping a whole wrap of the counter
  assign cap_irq_evt = push && ((ctrl.mode == ICC_MODE_EVERY) || (ncap_ff >= ctrl.cpi)); // R9 R10

  // =====================================================
  // control register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= ICC_CTRL_RESET;
    end else if (req.wr && req.addr == ICC_ADDR_CTRL) begin
      ctrl_ff <= req.wdata & ICC_CTRL_WMASK; // R16
    end
  end

  // =====================================================
  // interrupt status and mask; a status read clears, but a new event wins
  logic [2:0] ist_ff;
  logic [2:0] imask_ff;
  logic [2:0] ev;
  logic st_rd;

  assign ev = {o_wake, cap_evt & full, cap_irq_evt};
  assign st_rd = req.rd && (req.addr == ICC_ADDR_IRQ_STAT);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ist_ff <= 3'h0;
    end else begin
      ist_ff <= (st_rd ? 3'h0 : ist_ff) | ev;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      imask_ff <= 3'h0;
    end else if (req.wr && req.addr == ICC_ADDR_IRQ_MASK) begin
      imask_ff <= req.wdata[2:0];
    end
  end

  assign o_irq = |(ist_ff & imask_ff);

  // =====================================================
  // read data, one cycle after the strobe
  logic [15:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 16'h0000;
    case (req.addr)
      ICC_ADDR_CTRL: begin
        nxt_rdata = ctrl_ff; // R16
        nxt_rdata[ICC_BIT_OV] = ov_ff; // R11
        nxt_rdata[ICC_BIT_BNE] = (cnt_ff != 3'h0); // R12
      end
      ICC_ADDR_BUF: nxt_rdata = (cnt_ff != 3'h0) ? fifo_ff[rp_ff] : 16'h0000; // R17
      ICC_ADDR_IRQ_STAT: nxt_rdata = {13'h0000, ist_ff};
      ICC_ADDR_IRQ_MASK: nxt_rdata = {13'h0000, imask_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (req.rd) begin
      o_rdata <= nxt_rdata;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // =====================================================
  // assertions
  property p_off_no_push;
    @(posedge i_clk) disable iff (i_reset) off_mode |-> !push;
  endproperty
  a_off_no_push: assert property (p_off_no_push) else $error("capture while off"); // R3

  property p_ov_set;
    @(posedge i_clk) disable iff (i_reset) (cap_evt && full && !off_mode) |=> ov_ff;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("overflow not set"); // R17

  property p_off_flush;
    @(posedge i_clk) disable iff (i_reset) off_mode |=> (cnt_ff == 3'h0) && !ov_ff;
  endproperty
  a_off_flush: assert property (p_off_flush) else $error("off did not flush"); // R18

  property p_fall_mode;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl.mode == ICC_MODE_FALL && !halted && fall) |-> cap_evt;
  endproperty
  a_fall_mode: assert property (p_fall_mode) else $error("falling edge missed"); // R1

  property p_rise_no_fall;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl.mode == ICC_MODE_RISE && fall) |-> !cap_evt;
  endproperty
  a_rise_no_fall: assert property (p_rise_no_fall) else $error("fall captured"); // R1

  property p_idle_halt;
    @(posedge i_clk) disable iff (i_reset) halted |-> !cap_evt;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("capture in idle halt"); // R13

  property p_push_val;
    @(posedge i_clk) disable iff (i_reset)
      (push && !off_mode) |=> fifo_ff[$past(wp_ff)] == $past(cap_val);
  endproperty
  a_push_val: assert property (p_push_val) else $error("wrong value stored"); // R6

  property p_bne;
    @(posedge i_clk) disable iff (i_reset)
      (req.rd && req.addr == ICC_ADDR_CTRL) |=> o_rdata[ICC_BIT_BNE] == ($past(cnt_ff) != 3'h0);
  endproperty
  a_bne: assert property (p_bne) else $error("buffer flag wrong"); // R12

  property p_cnt_max;
    @(posedge i_clk) disable iff (i_reset) cnt_ff <= 3'(DEPTH);
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("fifo count above depth"); // R8

  property p_unimpl;
    @(posedge i_clk) disable iff (i_reset)
      (req.rd && req.addr == ICC_ADDR_CTRL) |=> o_rdata[15:14] == 2'h0 && o_rdata[12:8] == 5'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set"); // R16

  property p_irq_single;
    @(posedge i_clk) disable iff (i_reset)
      (push && ctrl.cpi == 2'h0) |-> cap_irq_evt;
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("missed capture irq"); // R9

  property p_every_edge;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl.mode == ICC_MODE_EVERY && !halted && (rise || fall)) |-> cap_evt;
  endproperty
  a_every_edge: assert property (p_every_edge) else $error("edge missed"); // R1

  property p_pre4_fire;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl.mode == ICC_MODE_RISE4 && !halted && rise && pre_ff == ICC_PRE4_LAST) |-> cap_evt;
  endproperty
  a_pre4_fire: assert property (p_pre4_fire) else $error("fourth rise missed"); // R2

  property p_unused_mode;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl.mode == ICC_MODE_UNUSED) |-> !cap_evt && !o_wake;
  endproperty
  a_unused_mode: assert property (p_unused_mode) else $error("unused mode active"); // R4

  property p_wake_no_capture;
    @(posedge i_clk) disable iff (i_reset) (ctrl.mode == ICC_MODE_WAKE) |-> !push;
  endproperty
  a_wake_no_capture: assert property (p_wake_no_capture) else $error("capture in wake mode"); // R5

  property p_wake_rise;
    @(posedge i_clk) disable iff (i_reset)
      (ctrl.mode == ICC_MODE_WAKE && rise && (i_cpu_sleep || i_cpu_idle)) |-> o_wake;
  endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("wake rise missed"); // R5

  property p_timer_sel;
    @(posedge i_clk) disable iff (i_reset)
      push |=> fifo_ff[$past(wp_ff)] ==
        ($past(ctrl.tmr_sel) ? $past(i_timer_b_count) : $past(i_timer_c_count));
  endproperty
  a_timer_sel: assert property (p_timer_sel) else $error("wrong timer captured"); // R7

  property p_every_irq;
    @(posedge i_clk) disable iff (i_reset)
      (push && ctrl.mode == ICC_MODE_EVERY) |-> cap_irq_evt;
  endproperty
  a_every_irq: assert property (p_every_irq) else $error("every-edge irq missed"); // R10

  property p_ov_sticky;
    @(posedge i_clk) disable iff (i_reset) (ov_ff && !off_mode) |=> ov_ff;
  endproperty
  a_ov_sticky: assert property (p_ov_sticky) else $error("overflow flag lost"); // R11

  property p_wake_capture;
    @(posedge i_clk) disable iff (i_reset)
      ((i_cpu_sleep || i_cpu_idle) && cap_evt) |-> o_wake;
  endproperty
  a_wake_capture: assert property (p_wake_capture) else $error("capture did not wake"); // R14

  property p_stat_set_wins;
    @(posedge i_clk) disable iff (i_reset) (st_rd && cap_irq_evt) |=> ist_ff[ICC_IRQ_CAP];
  endproperty
  a_stat_set_wins: assert property (p_stat_set_wins) else $error("status event lost"); // R9

  c_overflow: cover property (@(posedge i_clk) disable iff (i_reset) cap_evt && full);
  c_pre16: cover property (@(posedge i_clk) disable iff (i_reset)
    ctrl.mode == ICC_MODE_RISE16 && cap_evt);
  c_wake: cover property (@(posedge i_clk) disable iff (i_reset) o_wake);
  c_irq4: cover property (@(posedge i_clk) disable iff (i_reset) cap_irq_evt && ctrl.cpi == 2'h3);
endmodule

// >>> verification/icc_pin_model.sv
// far-side model: drives the capture input pin with clean pulses
`timescale 1ns/1ns
module icc_pin_model (
  input wire logic i_clk,
  output logic o_pin
);
  initial o_pin = 1'b0;
  // ==========================================
  // pulse: low, high and low again, each hold cycles long
  // holding low afterwards lets the falling edge land before the timers move
  task automatic pulse(input int hold);
    repeat (hold) @(posedge i_clk);
    o_pin <= 1'b1;
    repeat (hold) @(posedge i_clk);
    o_pin <= 1'b0;
    repeat (hold) @(posedge i_clk);
  endtask
endmodule

// >>> verification/icc_capture_tb.sv
// testbench: register-port sequences against the input capture channel
`timescale 1ns/1ns
module icc_capture_tb;
  import icc_pkg::*;
  logic i_clk, i_reset, pin, i_cpu_idle, i_cpu_sleep, i_wr, i_rd, o_irq, o_wake;
  logic [15:0] tb, tc, i_wdata, o_rdata, d;
  logic [1:0] i_addr;
  int n_mismatch, comparisons, n_wake, n;
  int np[8] = '{2, 2, 3, 3, 8, 16, 2, 2};
  int ne[8] = '{0, 4, 3, 3, 2, 1, 0, 0};
  // ==========================================
  // clock and instances
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  icc_pin_model pm (.i_clk(i_clk), .o_pin(pin));
  icc_capture dut (.i_clk(i_clk), .i_reset(i_reset), .i_capture_input_pin(pin),
    .i_timer_b_count(tb), .i_timer_c_count(tc), .i_cpu_idle(i_cpu_idle),
    .i_cpu_sleep(i_cpu_sleep), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_wake(o_wake));
  always @(posedge i_clk) if (o_wake === 1'b1) n_wake++;
  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // timers step before each pulse so each pulse's captures get a new value
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge i_clk);
      tb <= tb + 16'h0001;
      tc <= tc + 16'h0001;
      pm.pulse(5);
    end
  endtask
  // empty reads return zero, so nonzero reads count the stored captures
  task automatic drain(output int c);
    c = 0;
    repeat (5) begin
      rd(ICC_ADDR_BUF, d);
      if (d !== 16'h0000) c++;
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge i_clk);
    n_mismatch++;
    tally_and_finish;
  end
  // ==========================================
  // main sequence
  initial begin
    {i_reset, i_cpu_idle, i_cpu_sleep, i_wr, i_rd, i_addr, i_wdata} = '0;
    tb = 16'hB000;
    tc = 16'hC000;
    i_reset = 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(ICC_ADDR_CTRL, d);
    chk(d, 16'h0000);
    wr(ICC_ADDR_CTRL, 16'hFFFF);
    rd(ICC_ADDR_CTRL, d);
    chk(d, 16'h20E7);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      wr(ICC_ADDR_CTRL, 16'h0080);
      wr(ICC_ADDR_CTRL, 16'h0080 | 16'(m));
      pulses(np[m]);
      drain(n);
      chk(16'(n), 16'(ne[m]));
      rd(ICC_ADDR_CTRL, d);
      chk(d, 16'h0080 | 16'(m));
    end
    chk(16'(n_wake), 16'h0000);
    $display("test modes done");
    wr(ICC_ADDR_CTRL, 16'h0003);
    pulses(1);
    rd(ICC_ADDR_BUF, d);
    chk(d, tc);
    wr(ICC_ADDR_CTRL, 16'h0083);
    rd(ICC_ADDR_IRQ_STAT, d);
    pulses(5);
    rd(ICC_ADDR_CTRL, d);
    chk(d, 16'h009B);
    rd(ICC_ADDR_IRQ_STAT, d);
    chk(d, 16'h0003);
    for (int i = 4; i > 0; i--) begin
      rd(ICC_ADDR_BUF, d);
      chk(d, tb - 16'(i));
    end
    rd(ICC_ADDR_CTRL, d);
    chk(d, 16'h0093);
    wr(ICC_ADDR_CTRL, 16'h0080);
    rd(ICC_ADDR_CTRL, d);
    chk(d, 16'h0080);
    $display("test fifo done");
    wr(ICC_ADDR_IRQ_MASK, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wr(ICC_ADDR_CTRL, 16'h0080);
      wr(ICC_ADDR_CTRL, 16'h0083 | 16'(k << 5));
      rd(ICC_ADDR_IRQ_STAT, d);
      pulses(k);
      #1 chk({15'h0000, o_irq}, 16'h0000);
      pulses(1);
      #1 chk({15'h0000, o_irq}, 16'h0001);
      rd(ICC_ADDR_IRQ_STAT, d);
      chk(d, 16'h0001);
      @(posedge i_clk);
      #1 chk({15'h0000, o_irq}, 16'h0000);
    end
    wr(ICC_ADDR_CTRL, 16'h0080);
    wr(ICC_ADDR_CTRL, 16'h00E1);
    wr(ICC_ADDR_IRQ_MASK, 16'h0000);
    pulses(1);
    chk({15'h0000, o_irq}, 16'h0000);
    wr(ICC_ADDR_IRQ_MASK, 16'h0007);
    #1 chk({15'h0000, o_irq}, 16'h0001);
    rd(ICC_ADDR_IRQ_STAT, d);
    chk(d, 16'h0001);
    $display("test interrupts done");
    wr(ICC_ADDR_CTRL, 16'h0000);
    wr(ICC_ADDR_CTRL, 16'h0087);
    i_cpu_sleep <= 1'b1;
    pulses(1);
    i_cpu_sleep <= 1'b0;
    chk(16'(n_wake), 16'h0001);
    rd(ICC_ADDR_BUF, d);
    chk(d, 16'h0000);
    wr(ICC_ADDR_CTRL, 16'h0000);
    wr(ICC_ADDR_CTRL, 16'h2083);
    i_cpu_idle <= 1'b1;
    pulses(1);
    rd(ICC_ADDR_BUF, d);
    chk(d, 16'h0000);
    i_cpu_idle <= 1'b0;
    pulses(1);
    rd(ICC_ADDR_BUF, d);
    chk(d, tb);
    wr(ICC_ADDR_CTRL, 16'h0083);
    i_cpu_idle <= 1'b1;
    pulses(1);
    i_cpu_idle <= 1'b0;
    rd(ICC_ADDR_BUF, d);
    chk(d, tb);
    $display("test idle done");
    tally_and_finish;
  end
endmodule
